// ==== hdl/main_clock_prescaler.sv ====
// Main clock prescaler producing the peripheral clock enable
`timescale 1ns/1ps
`default_nettype none
module main_clock_prescaler (
	input  wire logic clk,
	input  wire logic rst_b,
	prescale_if.div   pif
);
	import main_clock_pkg::*;

	logic [6:0] count_q;
	logic [6:0] ratio;

	assign ratio = div_ratio(pif.prescale_divisor);

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			count_q  <= 7'h00;
			pif.tick <= 1'b1;
		end else if (!pif.prescale_enable || ratio == 7'h00) begin
			count_q  <= 7'h00;
			pif.tick <= 1'b1;
		end else if (count_q >= ratio - 7'h01) begin
			count_q  <= 7'h00;
			pif.tick <= 1'b1;
		end else begin
			count_q  <= count_q + 7'h01;
			pif.tick <= 1'b0;
		end
	end
endmodule // main_clock_prescaler
`default_nettype wire

// ==== hdl/main_clock_select_and_failure_detect.sv ====
// Main clock select, prescaler control and clock failure detection
`timescale 1ns/1ps
`default_nettype none
module main_clock_select_and_failure_detect #(
	parameter logic [3:0] STARTUP_SOURCE = main_clock_pkg::SRC_INT_FAST
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        config_change_guard_open,
	input  wire logic        main_clock_alive,
	input  wire logic        external_fast_osc_alive,
	input  wire logic        external_slow_xtal_alive,
	input  wire logic [5:0]  osc_status_in,
	output logic      [3:0]  main_source_select,
	output logic             clock_pin_output_enable,
	output logic             peripheral_clock,
	output logic             failure_detect_active,
	output logic             failure_irq,
	output logic             failure_nmi
);
	import main_clock_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic       clock_pin_output_enable_en_q;
	logic [3:0] src_sel_q;
	logic       presc_en_q;
	logic [3:0] presc_div_q;
	logic       cfd_en_q;
	logic       cfd_tst_q;
	logic [1:0] cfd_src_q;
	logic       irq_en_q;
	logic       irq_kind_q;
	logic       irq_flag_q;
	logic       lock_q;
	logic [7:0] ifast_ctrl_q;
	logic [7:0] ifast_trim_q;
	logic [7:0] pll_ctrl_q;
	logic [7:0] islow_ctrl_q;
	logic [7:0] xslow_ctrl_q;
	logic [7:0] xfast_ctrl_q;
	logic       ack_q;
	logic [7:0] rdata_q;

	// Synchronisers
	logic [2:0] alive_meta_q;
	logic [2:0] alive_q;
	logic [5:0] status_meta_q;
	logic [5:0] status_q;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [5:0] idx;
	logic [7:0] wdata;
	logic       req;
	logic       wr_go;
	logic       guarded;
	logic       wr_ok;
	logic       fail_now;
	logic       main_fail;
	logic       mon_alive;
	logic [7:0] rd_mux;

	assign idx   = avs_address[7:2];
	assign wdata = avs_writedata[7:0];
	assign req   = avs_read | avs_write;
	assign wr_go = avs_write & ack_q & avs_byteenable[0];

	assign avs_waitrequest = req & ~ack_q;

	function automatic logic is_guarded(input logic [5:0] i);
		case (i)
			IDX_CTRL_A, IDX_CTRL_B, IDX_CTRL_C, IDX_IRQ_CTRL,
			IDX_IFAST_CTRL, IDX_PLL_CTRL, IDX_ISLOW_CTRL,
			IDX_XSLOW_CTRL, IDX_XFAST_CTRL: is_guarded = 1'b1;
			default:                        is_guarded = 1'b0;
		endcase
	endfunction

	function automatic logic wr_hit(input logic [5:0] i, input logic [5:0] target);
		wr_hit = (i == target);
	endfunction

	assign guarded = is_guarded(idx);
	assign wr_ok   = wr_go & (~guarded | config_change_guard_open);

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_q <= RST_ZERO;
		end else if (avs_read & ~ack_q) begin
			rdata_q <= rd_mux;
		end
	end

	assign avs_readdata = {24'h000000, rdata_q};

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			alive_meta_q  <= 3'h0;
			alive_q       <= 3'h0;
			status_meta_q <= 6'h00;
			status_q      <= 6'h00;
		end else begin
			alive_meta_q  <= {external_slow_xtal_alive, external_fast_osc_alive,
				main_clock_alive};
			alive_q       <= alive_meta_q;
			status_meta_q <= osc_status_in;
			status_q      <= status_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Failure detection
	// ------------------------------------------------------------
	always_comb begin
		case (cfd_src_q)
			MON_MAIN:     mon_alive = alive_q[0];
			MON_EXT_FAST: mon_alive = alive_q[1];
			MON_EXT_SLOW: mon_alive = alive_q[2];
			default:      mon_alive = 1'b1;
		endcase
	end

	assign fail_now  = cfd_en_q & (cfd_tst_q | ~mon_alive);
	assign main_fail = fail_now & (cfd_src_q == MON_MAIN);

	assign failure_detect_active = cfd_en_q;

	// ------------------------------------------------------------
	// Main control A
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			clock_pin_output_enable_en_q <= RST_ZERO[POS_CLOCK_PIN_OUTPUT_ENABLE_EN];
		end else if (main_fail) begin
			clock_pin_output_enable_en_q <= 1'b0;
		end else if (wr_ok && wr_hit(idx, IDX_CTRL_A)) begin
			clock_pin_output_enable_en_q <= wdata[POS_CLOCK_PIN_OUTPUT_ENABLE_EN];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			src_sel_q <= RST_ZERO[3:0];
		end else if (main_fail) begin
			src_sel_q <= STARTUP_SOURCE;
		end else if (wr_ok && wr_hit(idx, IDX_CTRL_A)
			&& wdata[POS_SRC_LO +: 4] <= SRC_EXT_FAST) begin
			src_sel_q <= wdata[POS_SRC_LO +: 4];
		end
	end

	assign main_source_select      = src_sel_q;
	assign clock_pin_output_enable = clock_pin_output_enable_en_q;

	// ------------------------------------------------------------
	// Main control B
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			presc_en_q <= RST_ZERO[POS_PEN];
		end else if (wr_ok && wr_hit(idx, IDX_CTRL_B)) begin
			presc_en_q <= wdata[POS_PEN];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			presc_div_q <= RST_ZERO[3:0];
		end else if (wr_ok && wr_hit(idx, IDX_CTRL_B)
			&& div_ratio(wdata[POS_PRESCALE_DIVISOR_LO +: 4]) != 7'h00) begin
			presc_div_q <= wdata[POS_PRESCALE_DIVISOR_LO +: 4];
		end
	end

	// ------------------------------------------------------------
	// Main control C
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lock_q <= 1'b0;
		end else if (cfd_en_q & irq_en_q & irq_kind_q) begin
			lock_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfd_en_q <= RST_ZERO[POS_CFD_EN];
		end else if (wr_ok && wr_hit(idx, IDX_CTRL_C) && !lock_q) begin
			cfd_en_q <= wdata[POS_CFD_EN];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfd_tst_q <= RST_ZERO[POS_CFD_TST];
		end else if (wr_ok && wr_hit(idx, IDX_CTRL_C)) begin
			cfd_tst_q <= wdata[POS_CFD_TST];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfd_src_q <= RST_ZERO[1:0];
		end else if (wr_ok && wr_hit(idx, IDX_CTRL_C) && !lock_q
			&& wdata[POS_CFD_SRC_LO +: 2] != MON_RESERVED) begin
			cfd_src_q <= wdata[POS_CFD_SRC_LO +: 2];
		end
	end

	// ------------------------------------------------------------
	// Interrupt control and flag
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_en_q   <= RST_ZERO[POS_IRQ_EN];
			irq_kind_q <= RST_ZERO[POS_IRQ_KIND];
		end else if (wr_ok && wr_hit(idx, IDX_IRQ_CTRL) && !lock_q) begin
			irq_en_q   <= wdata[POS_IRQ_EN];
			irq_kind_q <= wdata[POS_IRQ_KIND];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_flag_q <= RST_ZERO[POS_IRQ_FLAG];
		end else if (fail_now) begin
			irq_flag_q <= 1'b1;
		end else if (wr_ok && wr_hit(idx, IDX_IRQ_FLAGS) && wdata[POS_IRQ_FLAG]) begin
			irq_flag_q <= 1'b0;
		end
	end

	assign failure_irq = irq_flag_q & irq_en_q & ~irq_kind_q;
	assign failure_nmi = irq_flag_q & irq_en_q & irq_kind_q;

	// ------------------------------------------------------------
	// Oscillator registers, storage only
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ifast_ctrl_q <= RST_IFAST_CTRL;
			ifast_trim_q <= RST_ZERO;
			pll_ctrl_q   <= RST_ZERO;
			islow_ctrl_q <= RST_ZERO;
			xslow_ctrl_q <= RST_ZERO;
			xfast_ctrl_q <= RST_ZERO;
		end else if (wr_ok) begin
			case (idx)
				IDX_IFAST_CTRL: ifast_ctrl_q <= wdata;
				IDX_IFAST_TRIM: ifast_trim_q <= wdata;
				IDX_PLL_CTRL:   pll_ctrl_q   <= wdata;
				IDX_ISLOW_CTRL: islow_ctrl_q <= wdata;
				IDX_XSLOW_CTRL: xslow_ctrl_q <= wdata;
				IDX_XFAST_CTRL: xfast_ctrl_q <= wdata;
				default:        ifast_ctrl_q <= ifast_ctrl_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_mux = RST_ZERO;
		case (idx)
			IDX_CTRL_A: begin
				rd_mux[POS_CLOCK_PIN_OUTPUT_ENABLE_EN]    = clock_pin_output_enable_en_q;
				rd_mux[POS_SRC_LO +: 4]  = src_sel_q;
			end
			IDX_CTRL_B: begin
				rd_mux[POS_PEN]          = presc_en_q;
				rd_mux[POS_PRESCALE_DIVISOR_LO +: 4] = presc_div_q;
			end
			IDX_CTRL_C: begin
				rd_mux[POS_CFD_EN]         = cfd_en_q;
				rd_mux[POS_CFD_TST]        = cfd_tst_q;
				rd_mux[POS_CFD_SRC_LO +: 2] = cfd_src_q;
			end
			IDX_IRQ_CTRL: begin
				rd_mux[POS_IRQ_EN]   = irq_en_q;
				rd_mux[POS_IRQ_KIND] = irq_kind_q;
			end
			IDX_IRQ_FLAGS:  rd_mux[POS_IRQ_FLAG] = irq_flag_q;
			IDX_STATUS:     rd_mux = {2'b00, status_q};
			IDX_IFAST_CTRL: rd_mux = ifast_ctrl_q;
			IDX_IFAST_TRIM: rd_mux = ifast_trim_q;
			IDX_PLL_CTRL:   rd_mux = pll_ctrl_q;
			IDX_ISLOW_CTRL: rd_mux = islow_ctrl_q;
			IDX_XSLOW_CTRL: rd_mux = xslow_ctrl_q;
			IDX_XFAST_CTRL: rd_mux = xfast_ctrl_q;
			default:        rd_mux = RST_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	prescale_if pif ();

	assign pif.prescale_enable  = presc_en_q;
	assign pif.prescale_divisor = presc_div_q;
	assign peripheral_clock     = pif.tick;

	main_clock_prescaler u_prescaler (
		.clk   (clk),
		.rst_b (rst_b),
		.pif   (pif.div)
	);

endmodule // main_clock_select_and_failure_detect
`default_nettype wire

// ==== shared/main_clock_pkg.sv ====
// Constants and helpers for the main clock control block
package main_clock_pkg;

	// ------------------------------------------------------------
	// Register indexes (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL_A     = 6'h00;
	localparam logic [5:0] IDX_CTRL_B     = 6'h01;
	localparam logic [5:0] IDX_CTRL_C     = 6'h02;
	localparam logic [5:0] IDX_IRQ_CTRL   = 6'h03;
	localparam logic [5:0] IDX_IRQ_FLAGS  = 6'h04;
	localparam logic [5:0] IDX_STATUS     = 6'h05;
	localparam logic [5:0] IDX_IFAST_CTRL = 6'h08;
	localparam logic [5:0] IDX_IFAST_TRIM = 6'h09;
	localparam logic [5:0] IDX_PLL_CTRL   = 6'h10;
	localparam logic [5:0] IDX_ISLOW_CTRL = 6'h18;
	localparam logic [5:0] IDX_XSLOW_CTRL = 6'h1C;
	localparam logic [5:0] IDX_XFAST_CTRL = 6'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int POS_CLOCK_PIN_OUTPUT_ENABLE_EN  = 7;
	localparam int POS_SRC_LO     = 0;
	localparam int POS_PEN        = 0;
	localparam int POS_PRESCALE_DIVISOR_LO    = 1;
	localparam int POS_CFD_EN     = 0;
	localparam int POS_CFD_TST    = 1;
	localparam int POS_CFD_SRC_LO = 2;
	localparam int POS_IRQ_EN     = 0;
	localparam int POS_IRQ_KIND   = 7;
	localparam int POS_IRQ_FLAG   = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_IFAST_CTRL = 8'h0C;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [3:0] SRC_INT_FAST  = 4'h0;
	localparam logic [3:0] SRC_INT_SLOW  = 4'h1;
	localparam logic [3:0] SRC_EXT_SLOW  = 4'h2;
	localparam logic [3:0] SRC_EXT_FAST  = 4'h3;
	localparam logic [1:0] MON_MAIN      = 2'h0;
	localparam logic [1:0] MON_EXT_FAST  = 2'h1;
	localparam logic [1:0] MON_EXT_SLOW  = 2'h2;
	localparam logic [1:0] MON_RESERVED  = 2'h3;

	// Prescaler ratio from divisor code, zero for reserved codes
	function automatic logic [6:0] div_ratio(input logic [3:0] code);
		case (code)
			4'h0:    div_ratio = 7'h02;
			4'h1:    div_ratio = 7'h04;
			4'h2:    div_ratio = 7'h08;
			4'h3:    div_ratio = 7'h10;
			4'h4:    div_ratio = 7'h20;
			4'h5:    div_ratio = 7'h40;
			4'h8:    div_ratio = 7'h06;
			4'h9:    div_ratio = 7'h0A;
			4'hA:    div_ratio = 7'h0C;
			4'hB:    div_ratio = 7'h18;
			4'hC:    div_ratio = 7'h30;
			default: div_ratio = 7'h00;
		endcase
	endfunction

endpackage

// ==== shared/prescale_if.sv ====
// Link between the control registers and the prescaler
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
	logic       prescale_enable;
	logic [3:0] prescale_divisor;
	logic       tick;

	modport ctrl (output prescale_enable, output prescale_divisor, input tick);
	modport div  (input prescale_enable, input prescale_divisor, output tick);
endinterface
`default_nettype wire

// ==== tb/main_clock_props.sv ====
// Port checker for the main clock control block
`timescale 1ns/1ps
`default_nettype none
module main_clock_props #(
	parameter logic [3:0] STARTUP_SOURCE = 4'h0
) (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic        config_change_guard_open,
	input wire logic [3:0]  main_source_select,
	input wire logic        clock_pin_output_enable,
	input wire logic        peripheral_clock,
	input wire logic        failure_detect_active,
	input wire logic        failure_irq,
	input wire logic        failure_nmi
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic       done;
	logic [5:0] idx;
	assign done = avs_write && !avs_waitrequest && avs_byteenable[0] && config_change_guard_open;
	assign idx  = avs_address[7:2];
	sequence s_wr_a;
		done && idx == 6'h00 && !failure_detect_active;
	endsequence
	property p_pin_write;
		s_wr_a |=> clock_pin_output_enable == $past(avs_writedata[7]);
	endproperty
	a_pin_write: assert property (p_pin_write) else $error("pin enable not written");
	property p_src_write;
		s_wr_a ##0 avs_writedata[3:0] <= 4'h3 |=> main_source_select == $past(avs_writedata[3:0]);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source not written");
	property p_src_reserved;
		s_wr_a ##0 avs_writedata[3:0] > 4'h3 |=> $stable(main_source_select);
	endproperty
	a_src_reserved: assert property (p_src_reserved) else $error("reserved source taken");
	property p_guard;
		avs_write && !avs_waitrequest && !config_change_guard_open && idx == 6'h00
			&& !failure_detect_active |=> $stable(main_source_select)
			&& $stable(clock_pin_output_enable);
	endproperty
	a_guard: assert property (p_guard) else $error("guarded write took effect");
	property p_detect_on;
		done && idx == 6'h02 && avs_writedata[0] |=> failure_detect_active;
	endproperty
	a_detect_on: assert property (p_detect_on) else $error("detection not enabled");
	property p_kind;
		!(failure_irq && failure_nmi);
	endproperty
	a_kind: assert property (p_kind) else $error("both interrupt kinds raised");
	property p_undivided;
		$rose(rst_b) |-> peripheral_clock;
	endproperty
	a_undivided: assert property (p_undivided) else $error("clock divided after reset");
	property p_pin_fall;
		$fell(clock_pin_output_enable) |-> $past(done && idx == 6'h00 && !avs_writedata[7])
			|| $past(failure_detect_active);
	endproperty
	a_pin_fall: assert property (p_pin_fall) else $error("pin enable dropped alone");
	property p_src_change;
		$changed(main_source_select) |-> $past(done && idx == 6'h00)
			|| ($past(failure_detect_active) && main_source_select == STARTUP_SOURCE);
	endproperty
	a_src_change: assert property (p_src_change) else $error("source changed alone");
	property p_one_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer late");
endmodule // main_clock_props
bind main_clock_select_and_failure_detect main_clock_props #(
	.STARTUP_SOURCE(STARTUP_SOURCE)
) u_props (
	.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .config_change_guard_open(config_change_guard_open),
	.main_source_select(main_source_select), .clock_pin_output_enable(clock_pin_output_enable),
	.peripheral_clock(peripheral_clock), .failure_detect_active(failure_detect_active),
	.failure_irq(failure_irq), .failure_nmi(failure_nmi)
);
`default_nettype wire

// ==== tb/tb_main_clock_select_and_failure_detect.sv ====
// Testbench of the main clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_main_clock_select_and_failure_detect;
	import main_clock_pkg::*;
	localparam logic [3:0] STARTUP_SOURCE_V = SRC_INT_FAST;
	logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, guard, m_ok, xf_ok, xs_ok;
	logic        pin_en, per_clk, det_act, irq, nmi;
	logic [7:0]  avs_address, a_exp, d;
	logic [31:0] avs_writedata, avs_readdata, rng;
	logic [3:0]  avs_byteenable, src, div_exp;
	logic [5:0]  osc;
	int          checks, miscompares, n;
	logic [5:0]  ri[9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h06, 6'h3F};
	logic [7:0]  rv[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2A, 8'h0C, 8'h00, 8'h00};
	main_clock_select_and_failure_detect dut (
		.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.config_change_guard_open(guard), .main_clock_alive(m_ok),
		.external_fast_osc_alive(xf_ok), .external_slow_xtal_alive(xs_ok),
		.osc_status_in(osc), .main_source_select(src), .clock_pin_output_enable(pin_en),
		.peripheral_clock(per_clk), .failure_detect_active(det_act), .failure_irq(irq),
		.failure_nmi(nmi)
	);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic int exp_ratio(input logic [3:0] c);
		int t[16] = '{2, 4, 8, 16, 32, 64, 0, 0, 6, 10, 12, 24, 48, 0, 0, 0};
		return t[c];
	endfunction
	function automatic logic [7:0] exp_a(input logic [7:0] old, input logic [7:0] w);
		return {w[7], 3'h0, (w[3:0] <= 4'h3) ? w[3:0] : old[3:0]};
	endfunction
	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus_wait();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 16);
		if (avs_waitrequest !== 1'b0) begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic wr(input logic [5:0] i, input logic [7:0] v, input logic [3:0] be = 4'hF);
		avs_address <= {i, 2'h0};
		avs_writedata <= {24'h000000, v};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		bus_wait();
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_check(input logic [5:0] i, input logic [7:0] v);
		logic [31:0] r;
		avs_address <= {i, 2'h0};
		avs_read <= 1'b1;
		bus_wait();
		r = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
		check("register", r, {24'h000000, v});
	endtask
	task automatic next_pulse();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (per_clk !== 1'b1 && n < 200);
		if (per_clk !== 1'b1) begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
	endtask
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		final_report();
	end
	initial begin
		{rst_b, avs_read, avs_write, guard, avs_address, avs_writedata} = '0;
		{m_ok, xf_ok, xs_ok, avs_byteenable, osc, rng, a_exp} = {7'h7F, 6'h2A, 32'h5C, 8'h00};
		do_reset();
		check("active", 32'(det_act), 32'h0);
		for (int i = 0; i < 9; i++) rd_check(ri[i], rv[i]);
		wr(6'h00, 8'h83);
		rd_check(6'h00, 8'h00);
		guard <= 1'b1;
		wr(6'h00, 8'h82, 4'hE);
		rd_check(6'h00, 8'h00);
		for (int i = 0; i < 12; i++) begin
			d = 8'(rnd());
			d = {d[7], 3'h0, (i < 4) ? 4'(i) : d[3:0]};
			wr(6'h00, d);
			a_exp = exp_a(a_exp, d);
			check("source", 32'(src), 32'(a_exp[3:0]));
			check("pin", 32'(pin_en), 32'(a_exp[7]));
		end
		div_exp = 4'h0;
		for (int c = 0; c < 16; c++) begin
			wr(6'h01, {3'h0, 4'(c), 1'b1});
			if (exp_ratio(4'(c)) != 0) div_exp = 4'(c);
			rd_check(6'h01, {3'h0, div_exp, 1'b1});
			repeat (3) next_pulse();
			check("period", 32'(n), 32'(exp_ratio(div_exp)));
		end
		wr(6'h01, 8'h06);
		repeat (3) next_pulse();
		check("undivided", 32'(n), 32'h1);
		wr(6'h03, 8'h01);
		wr(6'h02, 8'h05);
		check("active", 32'(det_act), 32'h1);
		repeat (6) @(posedge clk);
		rd_check(6'h04, 8'h00);
		xf_ok <= 1'b0;
		repeat (6) @(posedge clk);
		rd_check(6'h04, 8'h01);
		check("irq", {irq, nmi}, 32'h2);
		check("keep", 32'(src), 32'(a_exp[3:0]));
		xf_ok <= 1'b1;
		wr(6'h04, 8'h00);
		rd_check(6'h04, 8'h01);
		wr(6'h04, 8'h01);
		rd_check(6'h04, 8'h00);
		wr(6'h02, 8'h0B);
		rd_check(6'h02, 8'h0B);
		rd_check(6'h04, 8'h01);
		wr(6'h02, 8'h09);
		wr(6'h04, 8'h01);
		rd_check(6'h04, 8'h00);
		wr(6'h02, 8'h0D);
		rd_check(6'h02, 8'h09);
		wr(6'h00, 8'h83);
		wr(6'h02, 8'h03);
		rd_check(6'h00, {4'h0, STARTUP_SOURCE_V});
		wr(6'h02, 8'h00);
		wr(6'h04, 8'h01);
		m_ok <= 1'b0;
		repeat (6) @(posedge clk);
		rd_check(6'h04, 8'h00);
		m_ok <= 1'b1;
		wr(6'h03, 8'h81);
		wr(6'h02, 8'h05);
		wr(6'h02, 8'h00);
		wr(6'h02, 8'h09);
		rd_check(6'h02, 8'h05);
		wr(6'h03, 8'h00);
		rd_check(6'h03, 8'h81);
		xf_ok <= 1'b0;
		repeat (6) @(posedge clk);
		check("nmi", {irq, nmi}, 32'h1);
		xf_ok <= 1'b1;
		do_reset();
		wr(6'h02, 8'h04);
		rd_check(6'h02, 8'h04);
		final_report();
	end
endmodule // tb_main_clock_select_and_failure_detect
`default_nettype wire
